/* inc/osc_ctl_consts.vh */
// Constants for the oscillator control and watchdog-oscillator fail detect block
`ifndef OSC_CTL_CONSTS_VH
`define OSC_CTL_CONSTS_VH
// ==========================================
// Register map
`define OSC_ADDR_W        12
`define OSC_CTL_ADDR      12'hf86
`define OSC_IRQ_STAT_ADDR 12'hf80
`define OSC_IRQ_CLR_ADDR  12'hf81
`define OSC_IRQ_EN_ADDR   12'hf82
`define OSC_STATUS_ADDR   12'hf83
// ==========================================
// Control register fields and reset value
`define OSC_CTL_RESET     8'ha0
`define OSC_CTL_WMASK     8'hbf
`define OSC_BIT_INT_EN    7
`define OSC_BIT_WDT_EN    5
`define OSC_BIT_POF_EN    4
`define OSC_BIT_WDF_EN    3
`define OSC_SEL_MSB       2
`define OSC_SEL_LSB       0
`define OSC_SEL_WDT       3'h2
// ==========================================
// Unlock sequence
`define OSC_UNLOCK_KEY1   8'he7
`define OSC_UNLOCK_KEY2   8'h18
// ==========================================
// Interrupt status bits
`define OSC_IRQ_W         2
`define OSC_IRQ_WDT_FAIL  0
`define OSC_IRQ_PRI_FAIL  1
// ==========================================
// Fail detect timing
`define OSC_WDT_FAIL_CYCLES 14'd8004
`define OSC_CNT_W           14
`endif

/* hw/wdt_edge_sync.v */
// Three-stage synchroniser with edge detect for the watchdog oscillator clock
`timescale 1ns/100ps
module wdt_edge_sync
(
	input  wire clk,
	input  wire sys_rst,
	input  wire async_in,
	output reg  edge_seen
);
	reg s1_q;
	reg s2_q;
	reg s3_q;

	// ==========================================
	// Sync chain; only s2 and s3 are compared, s1 may be metastable
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			s1_q      <= 1'b0;
			s2_q      <= 1'b0;
			s3_q      <= 1'b0;
			edge_seen <= 1'b0;
		end
		else
		begin
			s1_q      <= async_in;
			s2_q      <= s1_q;
			s3_q      <= s2_q;
			edge_seen <= s2_q & ~s3_q;
		end
	end
endmodule // wdt_edge_sync

/* hw/osc_control.v */
// Oscillator control register with unlock sequence and watchdog oscillator fail detect
// Function
// - Watchdog oscillator failure raises an NMI-like event to the processor.
// - That failure only alerts; the clock source select is never changed by it.
// - After a watchdog failure, primary oscillator failure detection is inhibited.
// - Count system clocks without watchdog edge; fail at 8004 cycles.
// - All detection and all clocks disabled: device halts until power-on reset.
// - Control register writes need E7 then 18 written first to unlock.
// - Register relocks after one successful write following unlock.
// - Register holds oscillator enables, both detect enables and 3-bit source select.
`timescale 1ns/100ps
`include "osc_ctl_consts.vh"
module osc_control
(
	input  wire                   clk,
	input  wire                   sys_rst,
	input  wire                   por_rst,
	input  wire [`OSC_ADDR_W-1:0] addr,
	input  wire [7:0]             wr_data,
	input  wire                   wr_en,
	input  wire                   rd_en,
	output reg  [7:0]             rd_data,
	input  wire                   wdt_osc_clk,
	input  wire                   primary_osc_fail,
	output reg                    internal_osc_en,
	output reg                    watchdog_osc_en,
	output reg                    primary_osc_fail_detect_en,
	output reg                    wdt_osc_fail_detect_en,
	output reg  [2:0]             sysclk_source_select,
	output reg                    wdt_fail_nmi,
	output reg                    primary_fail_nmi,
	output reg                    device_halted,
	output reg                    irq
);
	localparam ST_LOCKED = 2'd0;
	localparam ST_KEY1   = 2'd1;
	localparam ST_OPEN   = 2'd2;

	reg  [7:0]              ctl_q;
	reg  [7:0]              ctl_d;
	reg  [1:0]              lock_q;
	reg  [1:0]              lock_d;
	reg  [`OSC_CNT_W-1:0]   cnt_q;
	reg                     wdt_failed_q;
	reg  [`OSC_IRQ_W-1:0]   stat_q;
	reg  [`OSC_IRQ_W-1:0]   en_q;
	reg                     halt_q;
	wire                    wdt_edge;
	wire                    ctl_wr;
	wire                    wdt_fail_ev;
	wire                    pri_fail_ev;
	wire [`OSC_IRQ_W-1:0]   ev_vec;

	// Address match helper, used by every decode below
	function hit;
		input [`OSC_ADDR_W-1:0] a;
		input [`OSC_ADDR_W-1:0] target;
		begin
			hit = (a == target);
		end
	endfunction

	// ==========================================
	// Watchdog clock edge detection
	wdt_edge_sync u_sync
	(
		.clk       (clk),
		.sys_rst   (sys_rst),
		.async_in  (wdt_osc_clk),
		.edge_seen (wdt_edge)
	);

	assign ctl_wr = wr_en & hit(addr, `OSC_CTL_ADDR);

	// ==========================================
	// Unlock sequencer
	always @*
	begin
		lock_d = lock_q;
		ctl_d  = ctl_q;
		if (ctl_wr)
		begin
			case (lock_q)
				ST_LOCKED:
					lock_d = (wr_data == `OSC_UNLOCK_KEY1) ? ST_KEY1 : ST_LOCKED;
				ST_KEY1:
					lock_d = (wr_data == `OSC_UNLOCK_KEY2) ? ST_OPEN : ST_LOCKED;
				ST_OPEN:
				begin
					// Reserved bit 6 stays zero
					ctl_d  = wr_data & `OSC_CTL_WMASK;
					lock_d = ST_LOCKED;
				end
				default:
					lock_d = ST_LOCKED;
			endcase
		end
	end

	// ==========================================
	// Control register and lock state
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			ctl_q  <= `OSC_CTL_RESET;
			lock_q <= ST_LOCKED;
		end
		else
		begin
			ctl_q  <= ctl_d;
			lock_q <= lock_d;
		end
	end

	// ==========================================
	// Watchdog oscillator fail counter; a slow system clock means slow detection
	assign wdt_fail_ev = ctl_q[`OSC_BIT_WDF_EN] & ~wdt_failed_q & ~wdt_edge
	                   & (cnt_q == `OSC_WDT_FAIL_CYCLES - 14'd1);
	// Primary detect dead once the watchdog has failed
	assign pri_fail_ev = ctl_q[`OSC_BIT_POF_EN] & ~wdt_failed_q & primary_osc_fail;
	assign ev_vec      = {pri_fail_ev, wdt_fail_ev};

	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			cnt_q        <= {`OSC_CNT_W{1'b0}};
			wdt_failed_q <= 1'b0;
		end
		else
		begin
			if (!ctl_q[`OSC_BIT_WDF_EN] || wdt_edge || wdt_failed_q)
				cnt_q <= {`OSC_CNT_W{1'b0}};
			else
				cnt_q <= cnt_q + 14'd1;
			if (wdt_fail_ev)
				wdt_failed_q <= 1'b1;
		end
	end

	// ==========================================
	// Halt latch: only power-on reset clears it, system reset cannot
	always @(posedge clk)
	begin
		if (por_rst)
			halt_q <= 1'b0;
		else if (!ctl_q[`OSC_BIT_INT_EN] && !ctl_q[`OSC_BIT_WDT_EN]
		         && !ctl_q[`OSC_BIT_POF_EN] && !ctl_q[`OSC_BIT_WDF_EN])
			halt_q <= 1'b1;
	end

	// ==========================================
	// Sticky status, set wins over clear
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			stat_q <= {`OSC_IRQ_W{1'b0}};
			en_q   <= {`OSC_IRQ_W{1'b0}};
		end
		else
		begin
			if (wr_en && hit(addr, `OSC_IRQ_CLR_ADDR))
				stat_q <= (stat_q & ~wr_data[`OSC_IRQ_W-1:0]) | ev_vec;
			else
				stat_q <= stat_q | ev_vec;
			if (wr_en && hit(addr, `OSC_IRQ_EN_ADDR))
				en_q <= wr_data[`OSC_IRQ_W-1:0];
		end
	end

	// ==========================================
	// Registered outputs; clock select follows software only, never the failure
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			internal_osc_en            <= 1'b1;
			watchdog_osc_en            <= 1'b1;
			primary_osc_fail_detect_en <= 1'b0;
			wdt_osc_fail_detect_en     <= 1'b0;
			sysclk_source_select       <= 3'h0;
			wdt_fail_nmi               <= 1'b0;
			primary_fail_nmi           <= 1'b0;
			irq                        <= 1'b0;
		end
		else
		begin
			internal_osc_en            <= ctl_d[`OSC_BIT_INT_EN];
			watchdog_osc_en            <= ctl_d[`OSC_BIT_WDT_EN];
			primary_osc_fail_detect_en <= ctl_d[`OSC_BIT_POF_EN];
			wdt_osc_fail_detect_en     <= ctl_d[`OSC_BIT_WDF_EN];
			sysclk_source_select       <= ctl_d[`OSC_SEL_MSB:`OSC_SEL_LSB];
			wdt_fail_nmi               <= wdt_fail_ev;
			primary_fail_nmi           <= pri_fail_ev;
			irq                        <= |((stat_q | ev_vec) & en_q);
		end
	end

	always @(posedge clk)
	begin
		if (por_rst)
			device_halted <= 1'b0;
		else
			device_halted <= halt_q;
	end

	// ==========================================
	// Read port, data in the cycle after the strobe; unmapped reads zero
	always @(posedge clk)
	begin
		if (sys_rst)
			rd_data <= 8'h00;
		else if (rd_en)
		begin
			if (hit(addr, `OSC_CTL_ADDR))
				rd_data <= ctl_q;
			else if (hit(addr, `OSC_IRQ_STAT_ADDR))
				rd_data <= {6'h00, stat_q};
			else if (hit(addr, `OSC_IRQ_EN_ADDR))
				rd_data <= {6'h00, en_q};
			else if (hit(addr, `OSC_STATUS_ADDR))
				rd_data <= {4'h0, halt_q, wdt_failed_q, lock_q};
			else
				rd_data <= 8'h00;
		end
		else
			rd_data <= 8'h00;
	end
endmodule // osc_control

/* sim/osc_control_assertions.sv */
// Port checker for the oscillator control block
`timescale 1ns/100ps
`include "osc_ctl_consts.vh"
module osc_control_assertions
(
	input wire        clk,
	input wire        sys_rst,
	input wire [11:0] addr,
	input wire [7:0]  wr_data,
	input wire        wr_en,
	input wire        rd_en,
	input wire [7:0]  rd_data,
	input wire        internal_osc_en,
	input wire        watchdog_osc_en,
	input wire        primary_osc_fail_detect_en,
	input wire        wdt_osc_fail_detect_en,
	input wire [2:0]  sysclk_source_select,
	input wire        wdt_fail_nmi,
	input wire        primary_fail_nmi,
	input wire        device_halted
);
	// ==========================================
	// Unlock tracker
	reg  [1:0] st_q;
	wire       ctl_wr = wr_en && addr == `OSC_CTL_ADDR;
	wire [7:0] ctl = {internal_osc_en, 1'b0, watchdog_osc_en, primary_osc_fail_detect_en,
		wdt_osc_fail_detect_en, sysclk_source_select};
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Any wrong key drops back to locked
	always @(posedge clk)
	begin
		if (sys_rst)
			st_q <= 2'd0;
		else if (ctl_wr)
			st_q <= (st_q == 2'd0 && wr_data == `OSC_UNLOCK_KEY1) ? 2'd1 :
				(st_q == 2'd1 && wr_data == `OSC_UNLOCK_KEY2) ? 2'd2 : 2'd0;
	end
	// ==========================================
	// Assertions
	chk_locked_hold: assert property (ctl_wr && st_q != 2'd2 |=> $stable(ctl))
		else $error("locked write moved control");
	chk_open_write: assert property (ctl_wr && st_q == 2'd2 |=> ctl == ($past(wr_data) & `OSC_CTL_WMASK))
		else $error("open write lost");
	chk_ctl_cause: assert property ($changed(ctl) |-> $past(ctl_wr) && $past(st_q) == 2'd2)
		else $error("control changed by itself");
	chk_nmi_pulse: assert property (wdt_fail_nmi |=> !wdt_fail_nmi)
		else $error("fail event repeated");
	chk_pri_dead: assert property (wdt_fail_nmi |=> !primary_fail_nmi [*8])
		else $error("primary event after fail");
	chk_halt_set: assert property (ctl[7:3] == 5'h00 |-> ##2 device_halted)
		else $error("halt missing");
	chk_rd_ctl: assert property (rd_en && addr == `OSC_CTL_ADDR |=> rd_data == ctl)
		else $error("control read wrong");
	chk_rd_idle: assert property (!rd_en |=> rd_data == 8'h00)
		else $error("read data not idle");
	cover property (wdt_fail_nmi);
	cover property (ctl_wr && st_q == 2'd2);
	cover property (device_halted);
endmodule // osc_control_assertions
bind osc_control osc_control_assertions u_chk (.*);

/* sim/osc_control_bench.sv */
// Self-checking bench for the oscillator control block
`timescale 1ns/100ps
`include "osc_ctl_consts.vh"
module osc_control_bench;
	reg         clk = 0, sys_rst = 1, por_rst = 1, wr_en = 0, rd_en = 0, rv = 0;
	reg         wdt_osc_clk = 0, primary_osc_fail = 0, wdt_run = 1;
	reg  [11:0] addr = 0;
	reg  [7:0]  wr_data = 0, v, q[$];
	wire [7:0]  rd_data;
	wire [2:0]  sysclk_source_select;
	wire        wdt_fail_nmi, primary_fail_nmi, device_halted, irq;
	int         err_count = 0, checked = 0, i;
	osc_control i_dut (.clk, .sys_rst, .por_rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .wdt_osc_clk,
		.primary_osc_fail, .internal_osc_en(), .watchdog_osc_en(), .primary_osc_fail_detect_en(),
		.wdt_osc_fail_detect_en(), .sysclk_source_select, .wdt_fail_nmi, .primary_fail_nmi, .device_halted, .irq);
	// ==========================================
	// Clocks, read monitor, hang guard
	always #4 clk = ~clk;
	// Odd half period of 21; every fourth watchdog toggle still lands on a clock edge
	always #21 if (wdt_run) wdt_osc_clk = ~wdt_osc_clk;
	always @(posedge clk) rv <= rd_en;
	always @(negedge clk) if (rv) chk(rd_data, q.pop_front());
	initial
	begin
		#200000;
		err_count++;
		end_of_test;
	end
	task automatic chk(input [7:0] s, input [7:0] e);
		checked++;
		if (s !== e)
		begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// One bus cycle; a read queues its expected data
	task automatic acc(input w, input [11:0] a, input [7:0] d);
		@(posedge clk);
		{wr_en, rd_en} <= {w, !w};
		addr <= a;
		wr_data <= d;
		if (!w)
			q.push_back(d);
		@(posedge clk);
		{wr_en, rd_en} <= 2'b00;
	endtask
	task automatic wctl(input [7:0] d);
		acc(1, `OSC_CTL_ADDR, `OSC_UNLOCK_KEY1);
		acc(1, `OSC_CTL_ADDR, `OSC_UNLOCK_KEY2);
		acc(1, `OSC_CTL_ADDR, d);
	endtask
	task end_of_test;
		$display("compares %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ==========================================
	// Main sequence
	initial
	begin
		v = $urandom(46);
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		por_rst <= 1'b0;
		acc(0, `OSC_CTL_ADDR, `OSC_CTL_RESET);
		acc(1, `OSC_CTL_ADDR, 8'h55);
		acc(1, `OSC_CTL_ADDR, `OSC_UNLOCK_KEY1);
		acc(1, `OSC_CTL_ADDR, 8'h77);
		acc(1, `OSC_CTL_ADDR, `OSC_UNLOCK_KEY2);
		acc(1, `OSC_CTL_ADDR, 8'h55);
		acc(0, `OSC_CTL_ADDR, `OSC_CTL_RESET);
		// Watchdog detect enable kept off so a random source select cannot break the software duty
		v = ($urandom & 8'h17) | 8'ha0;
		wctl(v);
		acc(0, `OSC_CTL_ADDR, v & `OSC_CTL_WMASK);
		acc(1, `OSC_CTL_ADDR, 8'h00);
		acc(0, `OSC_CTL_ADDR, v & `OSC_CTL_WMASK);
		acc(0, 12'hf8f, 8'h00);
		wctl(8'hb8);
		acc(1, `OSC_IRQ_EN_ADDR, 8'h01);
		wdt_run = 0;
		for (i = 0; i < 9000 && wdt_fail_nmi !== 1'b1; i++)
			@(negedge clk);
		chk(i > 7990 && i < 8020, 1'b1);
		chk(irq, 1'b1);
		@(posedge clk);
		primary_osc_fail <= 1'b1;
		acc(0, `OSC_IRQ_STAT_ADDR, 8'h01);
		acc(0, `OSC_CTL_ADDR, 8'hb8);
		acc(1, `OSC_IRQ_EN_ADDR, 8'h00);
		repeat (2) @(negedge clk);
		chk(irq, 1'b0);
		chk(primary_fail_nmi, 1'b0);
		acc(1, `OSC_IRQ_EN_ADDR, 8'h01);
		acc(1, `OSC_IRQ_CLR_ADDR, 8'h01);
		repeat (2) @(negedge clk);
		chk(irq, 1'b0);
		wctl(8'h00);
		// Halt latch then its output register: two edges after the control update
		repeat (3) @(negedge clk);
		chk(device_halted, 1'b1);
		end_of_test;
	end
endmodule // osc_control_bench
